/* hw/sxcfg_lane0.sv */
// How it works
// - Half-rate bit follows low-baud link speed
// - Rising recompute bit pulses drive recalculation
// - Transmit power accepts 000 and 011 only
// - Power and gate fields locked unless unlocked
// - Emphasis field resets to 0xC, 0 means none
// - Receive PLL power bit, resets to one
// - Receive gate needs PLL power and lock
// - Rising freq-clear bit resets recovery frequency
// - Equalizer level field resets to 0x5
// - Transmit-domain clock bit, resets to one
// - Signal-loss detect accepts 00 and 11 only
// - Word aligner enable bit, resets to one
// - Unused storage, read-zero bit, reserved storage
// - Unlock bit gates traffic-affecting controls
`timescale 1ns/10ps
module sxcfg_lane0 #(
   parameter int MAC_SEL = 0
) (
   // Clock and reset
   input  wire logic                                pclk,
   input  wire logic                                presetn,
   // APB slave
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [sxcfg_pkg::ADDR_W-1:0]        paddr,
   input  wire logic [sxcfg_pkg::DATA_W-1:0]        pwdata,
   input  wire logic [sxcfg_pkg::STRB_W-1:0]        pstrb,
   output logic      [sxcfg_pkg::DATA_W-1:0]        prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   // Lane status from the transceiver
   input  wire logic                                low_baud_speed,
   input  wire logic                                rx_pll_locked,
   // Lane controls to the transceiver
   output logic                                     half_rate,
   output logic                                     tx_drive_recompute,
   output logic      [sxcfg_pkg::TX_PWR_W-1:0]      tx_power_state,
   output logic      [sxcfg_pkg::TX_EMPH_W-1:0]     tx_emphasis,
   output logic                                     rx_pll_power,
   output logic                                     rx_output_gate,
   output logic                                     recovery_loop_freq_clear,
   output logic      [sxcfg_pkg::RX_EQ_W-1:0]       rx_equalizer_level,
   output logic      [sxcfg_pkg::LOOP_MODE_W-1:0]   recovery_loop_mode,
   output logic                                     tx_domain_clock_on,
   output logic      [sxcfg_pkg::LOS_W-1:0]         signal_loss_detect_cfg,
   output logic                                     word_align_en
);

   localparam int AW = sxcfg_pkg::ADDR_W;
   localparam int DW = sxcfg_pkg::DATA_W;

   // Refuse a MAC index that has no address
   if (MAC_SEL < 0 || MAC_SEL >= sxcfg_pkg::MAC_CNT) begin : g_bad_mac
      $error("MAC_SEL out of range");
   end

   // Refuse a package layout that the field map cannot serve
   if (DW != 32 || sxcfg_pkg::STRB_W * 8 != DW) begin : g_bad_word
      $error("Configuration word must be four bytes of eight bits");
   end
   if (AW < 17) begin : g_bad_addr
      $error("Address bus too narrow for the configuration offsets");
   end
   if (sxcfg_pkg::HALF_RATE_BIT != DW - 1 || sxcfg_pkg::RSVD_TOP_BIT != 0) begin : g_bad_map
      $error("Field map must span the whole word");
   end

   // Address of this copy
   localparam logic [AW-1:0] CFG_ADDR =
      (MAC_SEL == 0) ? sxcfg_pkg::CFG_OFF_MAC0 :
      (MAC_SEL == 1) ? sxcfg_pkg::CFG_OFF_MAC2 :
      (MAC_SEL == 2) ? sxcfg_pkg::CFG_OFF_MAC4 : sxcfg_pkg::CFG_OFF_MAC6;
   localparam logic [AW-1:0] GLB_ADDR =
      (MAC_SEL == 0) ? sxcfg_pkg::GLB_OFF_MAC0 :
      (MAC_SEL == 1) ? sxcfg_pkg::GLB_OFF_MAC2 :
      (MAC_SEL == 2) ? sxcfg_pkg::GLB_OFF_MAC4 : sxcfg_pkg::GLB_OFF_MAC6;

   // State
   logic [DW-1:0] cfg_reg;
   logic [DW-1:0] cfg_next;
   logic          unlock_reg;
   logic          unlock_next;
   logic          speed_prev_reg;
   logic          speed_prev_next;
   logic          speed_seen_reg;
   logic          speed_seen_next;
   logic [DW-1:0] prdata_reg;
   logic [DW-1:0] prdata_next;

   // Bus decode
   logic          hit_cfg;
   logic          hit_glb;
   logic          setup_ph;
   logic          access_ph;
   logic          wr_cfg;
   logic          wr_glb;
   logic [DW-1:0] lane_mask;
   logic [DW-1:0] wr_word;
   logic [DW-1:0] glb_word;
   logic          gate_eff;
   logic          speed_load;
   logic [1:0]    edge_level;
   logic [1:0]    edge_rise;

   // Screened fields of the merged write word
   logic [sxcfg_pkg::TX_PWR_W-1:0] wr_tx_pwr;
   logic [sxcfg_pkg::LOS_W-1:0]    wr_los;
   logic                           tx_pwr_legal;
   logic                           los_legal;
   logic                           gate_allowed;

   assign hit_cfg   = (paddr[AW-1:2] == CFG_ADDR[AW-1:2]);
   assign hit_glb   = (paddr[AW-1:2] == GLB_ADDR[AW-1:2]);
   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;
   assign wr_cfg    = access_ph & pwrite & hit_cfg;
   assign wr_glb    = access_ph & pwrite & hit_glb;

   // Zero wait states; unmapped addresses answer with an error
   // Read data is captured in setup, so no wait state is needed
   assign pready  = 1'b1;
   assign pslverr = access_ph & ~(hit_cfg | hit_glb);
   assign prdata  = prdata_reg;

   // Byte lanes of a write
   genvar b;
   generate
      for (b = 0; b < sxcfg_pkg::STRB_W; b++) begin : g_lane
         assign lane_mask[8*b +: 8] = {8{pstrb[b]}};
      end
   endgenerate

   assign wr_word = (pwdata & lane_mask) | (cfg_reg & ~lane_mask);

   // Only the two documented codes of each coded field are stored
   assign wr_tx_pwr    = wr_word[sxcfg_pkg::TX_PWR_LSB +: sxcfg_pkg::TX_PWR_W];
   assign wr_los       = wr_word[sxcfg_pkg::LOS_LSB +: sxcfg_pkg::LOS_W];
   assign tx_pwr_legal = (wr_tx_pwr == sxcfg_pkg::TX_PWR_OFF) ||
                         (wr_tx_pwr == sxcfg_pkg::TX_PWR_ON);
   assign los_legal    = (wr_los == sxcfg_pkg::LOS_OFF) ||
                         (wr_los == sxcfg_pkg::LOS_HEAVY);

   // A raise of the gate needs the PLL powered by the same write and locked
   assign gate_allowed = wr_word[sxcfg_pkg::PLL_PWR_BIT] & rx_pll_locked;

   // Receive outputs only pass with PLL powered and locked
   assign gate_eff = cfg_reg[sxcfg_pkg::RX_GATE_BIT]
                   & cfg_reg[sxcfg_pkg::PLL_PWR_BIT]
                   & rx_pll_locked;

   // Reload half-rate from the link speed after reset and on each change
   // A written bit 31 only lasts until the next speed change
   assign speed_load = ~speed_seen_reg | (low_baud_speed != speed_prev_reg);

   // Unlock and status word image
   always_comb begin
      glb_word = '0;
      glb_word[sxcfg_pkg::UNLOCK_BIT]      = unlock_reg;
      glb_word[sxcfg_pkg::STAT_LOCKED_BIT] = rx_pll_locked;
      glb_word[sxcfg_pkg::STAT_GATE_BIT]   = gate_eff;
   end

   // Configuration word next value
   always_comb begin
      cfg_next = cfg_reg;
      if (wr_cfg) begin
         cfg_next = wr_word;
         cfg_next[sxcfg_pkg::RSVD_RO_BIT] = 1'b0;
         if (!unlock_reg) begin
            // Traffic-affecting fields hold their stored values
            cfg_next[sxcfg_pkg::TX_PWR_LSB +: sxcfg_pkg::TX_PWR_W] =
               cfg_reg[sxcfg_pkg::TX_PWR_LSB +: sxcfg_pkg::TX_PWR_W];
            cfg_next[sxcfg_pkg::PLL_PWR_BIT] = cfg_reg[sxcfg_pkg::PLL_PWR_BIT];
            cfg_next[sxcfg_pkg::RX_GATE_BIT] = cfg_reg[sxcfg_pkg::RX_GATE_BIT];
         end else begin
            // Reserved transmit power codes leave the old code in place
            if (!tx_pwr_legal) begin
               cfg_next[sxcfg_pkg::TX_PWR_LSB +: sxcfg_pkg::TX_PWR_W] =
                  cfg_reg[sxcfg_pkg::TX_PWR_LSB +: sxcfg_pkg::TX_PWR_W];
            end
            // A refused raise stores a closed gate, not the old value
            if (!gate_allowed) begin
               cfg_next[sxcfg_pkg::RX_GATE_BIT] = 1'b0;
            end
         end
         // Reserved loss-detect codes leave the old code in place
         if (!los_legal) begin
            cfg_next[sxcfg_pkg::LOS_LSB +: sxcfg_pkg::LOS_W] =
               cfg_reg[sxcfg_pkg::LOS_LSB +: sxcfg_pkg::LOS_W];
         end
      end
      // Link speed overrides a write in the same cycle
      if (speed_load) begin
         cfg_next[sxcfg_pkg::HALF_RATE_BIT] = low_baud_speed;
      end
   end

   // Unlock bit next value
   always_comb begin
      unlock_next = unlock_reg;
      if (wr_glb && pstrb[0]) begin
         unlock_next = pwdata[sxcfg_pkg::UNLOCK_BIT];
      end
   end

   // Link speed tracking next values
   always_comb begin
      speed_prev_next = low_baud_speed;
      speed_seen_next = 1'b1;
   end

   // Read data captured in the setup cycle
   always_comb begin
      prdata_next = prdata_reg;
      if (setup_ph && !pwrite) begin
         if (hit_cfg) begin
            prdata_next = cfg_reg;
            prdata_next[sxcfg_pkg::RSVD_RO_BIT] = 1'b0;
         end else if (hit_glb) begin
            prdata_next = glb_word;
         end else begin
            prdata_next = '0;
         end
      end
   end

   // Configuration word register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= sxcfg_pkg::CFG_RESET;
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   // Unlock register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock_reg <= sxcfg_pkg::UNLOCK_RESET;
      end else begin
         unlock_reg <= unlock_next;
      end
   end

   // Link speed tracking registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         speed_prev_reg <= 1'b0;
         speed_seen_reg <= 1'b0;
      end else begin
         speed_prev_reg <= speed_prev_next;
         speed_seen_reg <= speed_seen_next;
      end
   end

   // Read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= '0;
      end else begin
         prdata_reg <= prdata_next;
      end
   end

   // Rising edges of the two trigger bits
   // Edges come from the stored word, so rewriting a 1 gives no pulse
   // Freq-clear resets to 1, so reset release gives no pulse
   assign edge_level = {cfg_reg[sxcfg_pkg::FREQ_CLR_BIT], cfg_reg[sxcfg_pkg::RECOMPUTE_BIT]};

   sxcfg_rise_det #(
      .WIDTH (2),
      .INIT  ({sxcfg_pkg::CFG_RESET[sxcfg_pkg::FREQ_CLR_BIT],
               sxcfg_pkg::CFG_RESET[sxcfg_pkg::RECOMPUTE_BIT]})
   ) u_rise (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (edge_level),
      .rise    (edge_rise)
   );

   assign tx_drive_recompute       = edge_rise[0];
   assign recovery_loop_freq_clear = edge_rise[1];

   // Transmit controls straight from the stored word
   assign half_rate              = cfg_reg[sxcfg_pkg::HALF_RATE_BIT];
   assign tx_power_state         = cfg_reg[sxcfg_pkg::TX_PWR_LSB +: sxcfg_pkg::TX_PWR_W];
   assign tx_emphasis            = cfg_reg[sxcfg_pkg::TX_EMPH_LSB +: sxcfg_pkg::TX_EMPH_W];

   // Receive and framing controls; the gate also needs the PLL lock
   assign rx_pll_power           = cfg_reg[sxcfg_pkg::PLL_PWR_BIT];
   assign rx_output_gate         = gate_eff;
   assign rx_equalizer_level     = cfg_reg[sxcfg_pkg::RX_EQ_LSB +: sxcfg_pkg::RX_EQ_W];
   assign recovery_loop_mode     = cfg_reg[sxcfg_pkg::LOOP_MODE_LSB +: sxcfg_pkg::LOOP_MODE_W];
   assign tx_domain_clock_on     = cfg_reg[sxcfg_pkg::TX_CLK_BIT];
   assign signal_loss_detect_cfg = cfg_reg[sxcfg_pkg::LOS_LSB +: sxcfg_pkg::LOS_W];
   assign word_align_en          = cfg_reg[sxcfg_pkg::ALIGN_BIT];

endmodule

/* hw/sxcfg_pkg.sv */
package sxcfg_pkg;

   // Bus geometry
   localparam int ADDR_W  = 20;
   localparam int DATA_W  = 32;
   localparam int STRB_W  = 4;
   localparam int MAC_CNT = 4;

   // Lane 0 configuration word, one per port-pair MAC
   localparam logic [ADDR_W-1:0] CFG_OFF_MAC0 = 20'h130b0;
   localparam logic [ADDR_W-1:0] CFG_OFF_MAC2 = 20'h132b0;
   localparam logic [ADDR_W-1:0] CFG_OFF_MAC4 = 20'h134b0;
   localparam logic [ADDR_W-1:0] CFG_OFF_MAC6 = 20'h136b0;

   // Unlock and status word placed beside each configuration word
   localparam logic [ADDR_W-1:0] GLB_OFF_MAC0 = 20'h130fc;
   localparam logic [ADDR_W-1:0] GLB_OFF_MAC2 = 20'h132fc;
   localparam logic [ADDR_W-1:0] GLB_OFF_MAC4 = 20'h134fc;
   localparam logic [ADDR_W-1:0] GLB_OFF_MAC6 = 20'h136fc;

   // Field positions, vector index (field bit 0 of the word is index 31)
   localparam int HALF_RATE_BIT   = 31;
   localparam int RECOMPUTE_BIT   = 30;
   localparam int UNUSED_LSB      = 24;
   localparam int UNUSED_W        = 6;
   localparam int RSVD_RO_BIT     = 23;
   localparam int TX_PWR_LSB      = 20;
   localparam int TX_PWR_W        = 3;
   localparam int TX_EMPH_LSB     = 16;
   localparam int TX_EMPH_W       = 4;
   localparam int PLL_PWR_BIT     = 15;
   localparam int RX_GATE_BIT     = 14;
   localparam int FREQ_CLR_BIT    = 13;
   localparam int RSVD_RW_LSB     = 11;
   localparam int RX_EQ_LSB       = 8;
   localparam int RX_EQ_W         = 3;
   localparam int LOOP_MODE_LSB   = 5;
   localparam int LOOP_MODE_W     = 3;
   localparam int TX_CLK_BIT      = 4;
   localparam int LOS_LSB         = 2;
   localparam int LOS_W           = 2;
   localparam int ALIGN_BIT       = 1;
   localparam int RSVD_TOP_BIT    = 0;

   // Reset image of the configuration word
   localparam logic [DATA_W-1:0] CFG_RESET = 32'h043ce513;

   // Legal codes of the coded fields
   localparam logic [TX_PWR_W-1:0] TX_PWR_OFF = 3'h0;
   localparam logic [TX_PWR_W-1:0] TX_PWR_ON  = 3'h3;
   localparam logic [LOS_W-1:0]    LOS_OFF    = 2'h0;
   localparam logic [LOS_W-1:0]    LOS_HEAVY  = 2'h3;

   // Unlock and status word layout
   localparam int UNLOCK_BIT      = 0;
   localparam int STAT_LOCKED_BIT = 8;
   localparam int STAT_GATE_BIT   = 9;
   localparam logic UNLOCK_RESET  = 1'b0;

endpackage

/* hw/sxcfg_rise_det.sv */
`timescale 1ns/10ps
module sxcfg_rise_det #(
   parameter int               WIDTH = 2,
   parameter logic [WIDTH-1:0] INIT  = '0
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Levels in, one-cycle pulses out
   input  wire logic [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise
);

   logic [WIDTH-1:0] prev_reg;
   logic [WIDTH-1:0] prev_next;

   // Refuse an empty detector
   if (WIDTH < 1) begin : g_bad_width
      $error("WIDTH must be at least one");
   end

   // One detector per bit
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         assign rise[i] = level[i] & ~prev_reg[i];
      end
   endgenerate

   // Previous level
   always_comb begin
      prev_next = level;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg <= INIT;
      end else begin
         prev_reg <= prev_next;
      end
   end

endmodule

/* testbench/sxcfg_lane0_checker.sv */
`timescale 1ns/10ps
module sxcfg_lane0_checker (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Bus side
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [19:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   // Lane side
   input wire logic        low_baud_speed,
   input wire logic        rx_pll_locked,
   input wire logic        half_rate,
   input wire logic        tx_drive_recompute,
   input wire logic [2:0]  tx_power_state,
   input wire logic        rx_pll_power,
   input wire logic        rx_output_gate,
   input wire logic        recovery_loop_freq_clear,
   input wire logic [2:0]  rx_equalizer_level,
   input wire logic [1:0]  signal_loss_detect_cfg
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed writes to the two words
   wire logic wr_cfg = psel && penable && pwrite && paddr[19:2] == 18'h04c2c;
   wire logic wr_glb = psel && penable && pwrite && paddr[19:2] == 18'h04c3f;
   logic unlock_reg;
   logic unlock_next;
   // Shadow of the unlock bit
   always_comb begin
      unlock_next = unlock_reg;
      if (wr_glb && pstrb[0]) unlock_next = pwdata[0];
   end
   // Shadow register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) unlock_reg <= 1'b0;
      else unlock_reg <= unlock_next;
   end
   property p_recomp;
      tx_drive_recompute |-> $past(wr_cfg && pstrb[3] && pwdata[30]) ##1 !tx_drive_recompute;
   endproperty
   a_recomp: assert property (p_recomp) else $error("recompute pulse without cause");
   property p_freq;
      recovery_loop_freq_clear |-> $past(wr_cfg && pstrb[1] && pwdata[13]);
   endproperty
   a_freq: assert property (p_freq) else $error("freq clear pulse without cause");
   property p_half;
      $changed(low_baud_speed) |-> ##[1:2] half_rate == low_baud_speed;
   endproperty
   a_half: assert property (p_half) else $error("half rate not following speed");
   property p_gate;
      rx_output_gate |-> rx_pll_power && rx_pll_locked;
   endproperty
   a_gate: assert property (p_gate) else $error("gate open without pll");
   property p_gate_rise;
      $rose(rx_output_gate) |-> $past(wr_cfg) || $rose(rx_pll_locked);
   endproperty
   a_gate_rise: assert property (p_gate_rise) else $error("gate opened without cause");
   property p_lock;
      wr_cfg && !unlock_reg |=> $stable(tx_power_state) && $stable(rx_pll_power);
   endproperty
   a_lock: assert property (p_lock) else $error("locked field changed");
   property p_txpwr;
      tx_power_state == sxcfg_pkg::TX_PWR_OFF || tx_power_state == sxcfg_pkg::TX_PWR_ON;
   endproperty
   a_txpwr: assert property (p_txpwr) else $error("reserved transmit power code");
   property p_los;
      signal_loss_detect_cfg == 2'h0 || signal_loss_detect_cfg == 2'h3;
   endproperty
   a_los: assert property (p_los) else $error("reserved loss detect code");
   property p_eq;
      wr_cfg && pstrb[1] |=> rx_equalizer_level == $past(pwdata[10:8]);
   endproperty
   a_eq: assert property (p_eq) else $error("equalizer not written");
   // Main scenarios
   c_recomp: cover property (tx_drive_recompute);
   c_freq: cover property (recovery_loop_freq_clear);
   c_gate: cover property (rx_output_gate ##1 !rx_output_gate);
   c_gate_rise: cover property ($rose(rx_output_gate));
endmodule
bind sxcfg_lane0 sxcfg_lane0_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .low_baud_speed(low_baud_speed), .rx_pll_locked(rx_pll_locked), .half_rate(half_rate),
   .tx_drive_recompute(tx_drive_recompute), .tx_power_state(tx_power_state),
   .rx_pll_power(rx_pll_power), .rx_output_gate(rx_output_gate),
   .recovery_loop_freq_clear(recovery_loop_freq_clear),
   .rx_equalizer_level(rx_equalizer_level), .signal_loss_detect_cfg(signal_loss_detect_cfg));

/* testbench/tb.sv */
`timescale 1ns/10ps
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        low_baud_speed, rx_pll_locked, half_rate, tx_drive_recompute;
   logic        rx_pll_power, rx_output_gate, recovery_loop_freq_clear;
   logic        tx_domain_clock_on, word_align_en;
   logic [19:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb, tx_emphasis;
   logic [2:0]  tx_power_state, rx_equalizer_level, recovery_loop_mode;
   logic [1:0]  signal_loss_detect_cfg;
   int          num_errors, checks, cycles;
   localparam logic [19:0] CA = sxcfg_pkg::CFG_OFF_MAC0;
   localparam logic [19:0] GA = sxcfg_pkg::GLB_OFF_MAC0;
   // Block under test
   sxcfg_lane0 #(.MAC_SEL(0)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .low_baud_speed(low_baud_speed),
      .rx_pll_locked(rx_pll_locked), .half_rate(half_rate),
      .tx_drive_recompute(tx_drive_recompute), .tx_power_state(tx_power_state),
      .tx_emphasis(tx_emphasis), .rx_pll_power(rx_pll_power), .rx_output_gate(rx_output_gate),
      .recovery_loop_freq_clear(recovery_loop_freq_clear),
      .rx_equalizer_level(rx_equalizer_level), .recovery_loop_mode(recovery_loop_mode),
      .tx_domain_clock_on(tx_domain_clock_on), .signal_loss_detect_cfg(signal_loss_detect_cfg),
      .word_align_en(word_align_en));
   // Clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One bus transfer, waits for pready
   task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input string n, input logic [19:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'hf);
      check(n, rd, e);
   endtask
   task automatic close_out;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         close_out();
      end
   end
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, low_baud_speed} = '0;
      rx_pll_locked = 1'b1;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("cfg reset", CA, 32'h043ce513);
      check("outs", {tx_power_state, tx_emphasis, rx_pll_power, rx_output_gate,
         rx_equalizer_level, tx_domain_clock_on, signal_loss_detect_cfg, word_align_en},
         {3'h3, 4'hc, 1'b1, 1'b1, 3'h5, 1'b1, 2'h0, 1'b1});
      rdchk("status", GA, 32'h300);
      apb(1'b0, 20'h13000, 32'h0, 4'hf);
      check("unmapped err", err, 32'h1);
      check("unmapped data", rd, 32'h0);
      // Locked write keeps power and gate; aligner off, clock kept on
      apb(1'b1, CA, 32'h00800211, 4'hf);
      rdchk("locked", CA, 32'h0030c211);
      check("emph", tx_emphasis, 32'h0);
      check("align clk", {word_align_en, tx_domain_clock_on}, 32'h1);
      apb(1'b1, CA, 32'h4030e211, 4'hf);
      #1 check("pulse", {tx_drive_recompute, recovery_loop_freq_clear}, 2'h3);
      @(posedge pclk);
      #1 check("pulse end", {tx_drive_recompute, recovery_loop_freq_clear}, 2'h0);
      apb(1'b1, CA, 32'h4030e211, 4'hf);
      #1 check("no pulse", {tx_drive_recompute, recovery_loop_freq_clear}, 2'h0);
      // Unlocked writes
      apb(1'b1, GA, 32'h1, 4'h1);
      apb(1'b1, CA, 32'h4000e215, 4'hf);
      rdchk("unlocked", CA, 32'h4000e211);
      check("tx off gate", {tx_power_state, rx_output_gate}, 4'h1);
      @(posedge pclk);
      rx_pll_locked <= 1'b0;
      @(posedge pclk);
      #1 check("gate lost", rx_output_gate, 32'h0);
      rdchk("status", GA, 32'h1);
      apb(1'b1, CA, 32'h4050a21d, 4'hf);
      rdchk("rsvd tx", CA, 32'h4000a21d);
      check("los", signal_loss_detect_cfg, 32'h3);
      @(posedge pclk);
      rx_pll_locked <= 1'b1;
      // Gate raise refused with PLL unpowered in the same write; loop mode still written
      apb(1'b1, CA, 32'h400062fd, 4'hf);
      rdchk("gate refused", CA, 32'h400022fd);
      check("mode", recovery_loop_mode, 32'h7);
      apb(1'b1, CA, 32'h4000e2fd, 4'hf);
      #1 check("gate raised", rx_output_gate, 32'h1);
      @(posedge pclk);
      low_baud_speed <= 1'b1;
      repeat (3) @(posedge pclk);
      rdchk("half", CA, 32'hc000e2fd);
      check("half pin", half_rate, 32'h1);
      // Lock again; bit 31 written to match the link speed
      apb(1'b1, GA, 32'h0, 4'h1);
      apb(1'b1, CA, 32'h8030c2fd, 4'hf);
      rdchk("relocked", CA, 32'h8000c2fd);
      close_out();
   end
endmodule
